// >>> dac_serial_load_control_test.sv
`timescale 1ns/1ns
`default_nettype none

module dac_serial_load_control_test;
    logic clk, nrst, ce, sclk, cs_n, sdi, sdo, sdo_oe, strobe_n, hw_reset_n, shutdown, park;
    logic [17:0] in_code;
    logic [23:0] w, prev, rx, exp_in;
    logic fmt;
    dsl_pkg::dsl_cfg_t cfg;
    dsl_pkg::dsl_out_t dac_out;
    wire sdo_line;
    int n_errors = 0;
    int n_compared = 0;

    // The serial output only reaches the host while enabled.
    assign sdo_line = sdo_oe ? sdo : 1'bz;

    dsl_core dut (.clk(clk), .nrst(nrst), .ce(ce), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .sdo(sdo), .sdo_oe(sdo_oe), .cfg(cfg), .latch_load_strobe_n(strobe_n),
        .hw_reset_n(hw_reset_n), .shutdown_request(shutdown), .dac_out(dac_out),
        .vout_ground_park(park), .input_reg_code(in_code));

    dsl_host_model host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo_line));

    // System clock.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Expected latch code: twos complement input is moved to offset binary.
    function automatic logic [23:0] exp_code(input logic [23:0] x, input logic f);
        return {6'h00, f ? x[17:0] : x[17:0] ^ dsl_pkg::CODE_MSB};
    endfunction : exp_code

    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic final_report();
        if (n_errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    // Pulse the hardware reset and expect the selected reset code.
    task automatic hw_reset(input logic rsel);
        @(posedge clk);
        cfg.reset_code_select <= rsel;
        hw_reset_n <= 1'b0;
        repeat (4) @(posedge clk);
        hw_reset_n <= 1'b1;
        repeat (6) @(posedge clk);
        check("reset code", rsel ? 24'h020000 : 24'h000000, {6'h00, dac_out.code});
    endtask : hw_reset

    // About a dozen frames of some four microseconds each fit many times over in 50,000 cycles.
    initial begin
        #400000;
        n_errors++;
        final_report();
    end

    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        cfg = '{1'b1, 1'b0, 1'b1, 1'b0};
        strobe_n = 1'b1;
        hw_reset_n = 1'b1;
        shutdown = 1'b0;
        void'($urandom(85121));
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (8) @(posedge clk);
        check("power-on code", 24'h020000, {6'h00, dac_out.code});
        hw_reset(1'b1);
        hw_reset(1'b0);
        // A write with the strobe high reaches only the input register.
        prev = 24'($urandom);
        host.xfer(prev, 24, rx);
        repeat (8) @(posedge clk);
        check("input register", exp_code(prev, 1'b1), {6'h00, in_code});
        check("held code", 24'h000000, {6'h00, dac_out.code});
        check("sdo enable", 24'h000000, {23'h0, sdo_oe});
        @(posedge clk);
        strobe_n <= 1'b0;
        repeat (8) @(posedge clk);
        check("latched code", exp_code(prev, 1'b1), {6'h00, dac_out.code});
        // A short frame is dropped.
        host.xfer(24'hffffff, 12, rx);
        repeat (8) @(posedge clk);
        check("short frame", exp_code(prev, 1'b1), {6'h00, in_code});
        host.xfer(prev, 24, rx);
        exp_in = exp_code(prev, 1'b1);
        // Random frames in both read-back modes with stray clocks between them.
        for (int i = 0; i < 8; i++) begin
            w = 24'($urandom);
            fmt = (i == 0) ? 1'b0 : 1'($urandom);
            @(posedge clk);
            cfg.code_format_select <= fmt;
            cfg.readback_source_select <= (i == 1) ? 1'b1 : (i == 0) ? 1'b0 : 1'($urandom);
            cfg.gain_select <= 1'($urandom);
            shutdown <= 1'($urandom);
            host.stray(3);
            host.xfer(w, 24, rx);
            repeat (8) @(posedge clk);
            check("serial out", cfg.readback_source_select ? exp_in : prev, rx);
            check("code", exp_code(w, fmt), {6'h00, dac_out.code});
            check("gain", {23'h0, cfg.gain_select}, {23'h0, dac_out.gain_two});
            check("power down", {23'h0, shutdown}, {23'h0, dac_out.powered_down});
            check("ground park", {23'h0, shutdown}, {23'h0, park});
            check("sdo enable", 24'h000000, {23'h0, sdo_oe});
            prev = w;
            exp_in = exp_code(w, fmt);
        end
        final_report();
    end
endmodule : dac_serial_load_control_test

`default_nettype wire

// >>> dsl_core.sv
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// RULE1: While the load strobe is low the latch follows the input register and the output code updates with it.
// RULE2: After reset the registers hold 20000h if the reset code select is high, else 00000h.
// RULE3: Buffer gain is one when the gain pin is low and two when it is high.
// RULE4: Incoming codes are straight binary when the format pin is high and twos complement when low.
// RULE5: A low level on the hardware reset pin resets the device.
// RULE6: A high power-down request parks the output on ground through a resistor instead of driving it.
// RULE7: Serial clock edges are ignored and no bit is captured while chip select is high.
// RULE8: Serial data out is high impedance whenever chip select is high.
// RULE9: With the source select high, serial data out shifts out the input register contents.
// RULE10: With the source select low, serial data out shifts out the serial shift register contents.
// RULE11: Output voltage is span over 262144 times code times gain plus the low reference, saturating at supply.
// RULE12: The host keeps chip select and the load strobe pulled high while undriven.
// RULE13: In daisy chain each serial output bit is the input bit from 24 serial clocks earlier.
// RULE14: The output holds its reset code until the host completes a valid write.
// RULE15: Data are sampled on rising serial clock while selected and loaded into the input register on chip select rise.
module dsl_core (
    // System clock domain.
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // Serial link; sdi is clocked by the host's serial clock, sdo and sdo_oe by clk.
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    // Static pins and strobes from the board.
    input wire dsl_pkg::dsl_cfg_t cfg,
    input wire logic latch_load_strobe_n,
    input wire logic hw_reset_n,
    input wire logic shutdown_request,
    // Analog-facing outputs.
    output dsl_pkg::dsl_out_t dac_out,
    output logic vout_ground_park,
    output logic [17:0] input_reg_code
);

    // Link domain state.
    logic [23:0] shift_reg;
    logic [4:0] bit_cnt;
    logic frame_full;
    logic [17:0] link_snapshot;
    logic snap_toggle;
    logic sdo_bit;
    dsl_pkg::dsl_state_t state;
    dsl_pkg::dsl_state_t next_state;

    // System domain state.
    logic [17:0] input_reg;
    logic [17:0] latch_reg;
    logic written;
    logic snap_seen;
    logic [17:0] rb_snapshot;

    // Synchronised pins.
    logic [5:0] pin_raw;
    logic [5:0] pin_sync;
    logic latch_load_strobe_n_low_s;
    logic rst_low_s;
    logic pdn_s;
    logic rsel_s;
    logic gain_s;
    logic fmt_s;
    logic snap_tog_s;
    logic [17:0] rb_code_s;
    logic cs_high_s;
    logic cs_low_s;
    logic sdo_bit_s;
    logic [1:0] boot_cnt;

    // All board pins except the readback source select cross into clk; inversions make zero the idle level at reset.
    assign pin_raw = {~latch_load_strobe_n, ~hw_reset_n, shutdown_request,
                      cfg.reset_code_select, cfg.gain_select, ~cfg.code_format_select};
    dsl_sync #(.WIDTH(6)) u_pin_sync (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .d(pin_raw),
        .q(pin_sync)
    );
    assign latch_load_strobe_n_low_s = pin_sync[5];
    assign rst_low_s = pin_sync[4];
    assign pdn_s = pin_sync[3];
    assign rsel_s = pin_sync[2];
    assign gain_s = pin_sync[1];
    assign fmt_s = ~pin_sync[0];

    // The frame toggle is the event that crosses; the snapshot is stable while it travels.
    dsl_sync #(.WIDTH(1)) u_tog_sync (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .d(snap_toggle),
        .q(snap_tog_s)
    );

    // ---------------- Link domain ----------------

    // Asynchronous clear of the bit counter and frame state from chip select alone.
    wire link_idle = cs_n;

    // Frame sequencing: idle until the first edge, shift, done after 24 bits.
    always_comb begin
        next_state = state;
        unique case (state)
            dsl_pkg::DSL_IDLE: next_state = dsl_pkg::DSL_SHIFT;
            dsl_pkg::DSL_SHIFT: next_state = (bit_cnt == dsl_pkg::FRAME_LAST) ? dsl_pkg::DSL_DONE : state;
            dsl_pkg::DSL_DONE: next_state = state;
        endcase
    end
    assign frame_full = (state == dsl_pkg::DSL_DONE);

    // Capture on rising sclk only while selected; chip select high clears the bit counter.
    always_ff @(posedge sclk or posedge link_idle) begin
        if (link_idle) begin
            bit_cnt <= 5'h00; // RULE7
            state <= dsl_pkg::DSL_IDLE;
        end else begin
            shift_reg <= {shift_reg[22:0], sdi}; // RULE15
            bit_cnt <= (bit_cnt == dsl_pkg::FRAME_LAST) ? bit_cnt : bit_cnt + 5'h01;
            state <= next_state;
        end
    end

    // The transfer is made on chip select rising; only a full frame counts as a valid write.
    // The link has no free-running clock to release a reset, so nrst clears the toggle directly.
    // Chip select rests high while nrst is low, so no frame edge can meet the release.
    always_ff @(posedge cs_n or negedge nrst) begin
        if (!nrst) begin
            link_snapshot <= dsl_pkg::RESET_CODE_ZERO;
            snap_toggle <= 1'b0;
        end else if (frame_full) begin
            link_snapshot <= shift_reg[17:0]; // RULE15
            snap_toggle <= ~snap_toggle;
        end
    end

    // The output bit is picked from link state that moves on rising sclk only.
    // It reaches the pad three clk edges later, so at each rising edge the host still sees the previous bit.
    // Limitation: the serial clock must stay several clk periods slow for that margin to hold.
    // Stand-alone shifts the held input register copy; daisy chain shifts the frame 24 bits late.
    wire [4:0] rb_idx = dsl_pkg::FRAME_LAST - bit_cnt;
    wire rb_bit = (rb_idx < 5'h12) ? rb_code_s[rb_idx] : 1'b0;
    assign sdo_bit = cfg.readback_source_select ? rb_bit : shift_reg[23]; // RULE9 RULE10 RULE13
    dsl_sync #(.WIDTH(1)) u_sdo_sync (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .d(sdo_bit),
        .q(sdo_bit_s)
    );

    // Chip select crosses inverted so that the synchroniser's reset value means deselected.
    wire cs_sel = ~cs_n;
    dsl_sync #(.WIDTH(1)) u_cs_sync (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .d(cs_sel),
        .q(cs_low_s)
    );
    assign cs_high_s = ~cs_low_s;
    assign rb_code_s = rb_snapshot;

    // ---------------- System domain ----------------

    // The pins need a few clk edges to pass their synchronisers after nrst.
    // The reset code is reloaded until they have settled, so power-on honours the select pin.
    wire booting = (boot_cnt != 2'h0);
    wire load_reset = rst_low_s || booting;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            boot_cnt <= 2'(dsl_pkg::SYNC_STAGES + 1);
        end else if (ce && booting) begin
            boot_cnt <= boot_cnt - 2'h1;
        end
    end

    // Input register, DAC latch and write tracking; hardware reset loads the selected code.
    wire [17:0] reset_code = rsel_s ? dsl_pkg::RESET_CODE_MID : dsl_pkg::RESET_CODE_ZERO; // RULE2
    wire new_word = snap_tog_s ^ snap_seen;
    // Twos complement input is offset to binary by flipping the top bit.
    wire [17:0] fmt_word = fmt_s ? link_snapshot : (link_snapshot ^ dsl_pkg::CODE_MSB); // RULE4
    always_ff @(posedge clk) begin
        if (!nrst || load_reset) begin
            input_reg <= reset_code; // RULE5
            latch_reg <= reset_code;
            written <= 1'b0;
            snap_seen <= snap_tog_s;
        end else if (ce) begin
            snap_seen <= snap_tog_s;
            if (new_word) begin
                input_reg <= fmt_word;
                written <= 1'b1;
            end
            if (latch_load_strobe_n_low_s && written) begin
                latch_reg <= new_word ? fmt_word : input_reg; // RULE1 RULE14
            end
        end
    end

    // The readback copy changes only between frames, so the link can read it without a hazard.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rb_snapshot <= dsl_pkg::RESET_CODE_ZERO;
        end else if (ce && cs_high_s) begin
            rb_snapshot <= input_reg;
        end
    end

    // Outputs toward the analog section and the pad, all from flops.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            dac_out <= '0;
            vout_ground_park <= 1'b0;
            input_reg_code <= dsl_pkg::RESET_CODE_ZERO;
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
        end else if (ce) begin
            dac_out.code <= latch_reg; // RULE11
            dac_out.gain_two <= gain_s; // RULE3
            dac_out.powered_down <= pdn_s;
            vout_ground_park <= pdn_s; // RULE6
            input_reg_code <= input_reg;
            sdo <= sdo_bit_s;
            sdo_oe <= ~cs_high_s; // RULE8
        end
    end

    // Checks.
    property p_oe_off;
        @(posedge clk) disable iff (!nrst)
        (ce && cs_high_s) |=> !sdo_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("sdo driven while deselected"); // RULE8

    property p_park;
        @(posedge clk) disable iff (!nrst)
        ce |=> (vout_ground_park == $past(pdn_s));
    endproperty
    a_park: assert property (p_park) else $error("power-down park wrong"); // RULE6

    property p_gain;
        @(posedge clk) disable iff (!nrst)
        ce |=> (dac_out.gain_two == $past(gain_s));
    endproperty
    a_gain: assert property (p_gain) else $error("gain wrong"); // RULE3

    property p_hold;
        @(posedge clk) disable iff (!nrst)
        (!written && !load_reset) |=> $stable(latch_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("latch moved before write"); // RULE14

    property p_reset;
        @(posedge clk) disable iff (!nrst)
        rst_low_s |=> (input_reg == $past(reset_code)) && !written;
    endproperty
    a_reset: assert property (p_reset) else $error("reset code wrong"); // RULE2

    property p_boot;
        @(posedge clk) disable iff (!nrst)
        booting |=> (input_reg == $past(reset_code)) && !written;
    endproperty
    a_boot: assert property (p_boot) else $error("power-on code wrong"); // RULE2

    property p_latch;
        @(posedge clk) disable iff (!nrst)
        (ce && latch_load_strobe_n_low_s && written && !new_word && !rst_low_s) |=> (latch_reg == $past(input_reg));
    endproperty
    a_latch: assert property (p_latch) else $error("latch not transparent"); // RULE1

    property p_fmt;
        @(posedge clk) disable iff (!nrst)
        (ce && new_word && !rst_low_s) |=> (input_reg[17] == ($past(link_snapshot[17]) ^ !$past(fmt_s)));
    endproperty
    a_fmt: assert property (p_fmt) else $error("format wrong"); // RULE4

    property p_code_out;
        @(posedge clk) disable iff (!nrst)
        ce |=> (dac_out.code == $past(latch_reg));
    endproperty
    a_code_out: assert property (p_code_out) else $error("code output lags"); // RULE11

    c_write: cover property (@(posedge clk) disable iff (!nrst) new_word);
    c_load: cover property (@(posedge clk) disable iff (!nrst) latch_load_strobe_n_low_s && written);
    c_pdn: cover property (@(posedge clk) disable iff (!nrst) pdn_s);
    c_readback: cover property (@(posedge clk) disable iff (!nrst) !cs_high_s && cfg.readback_source_select);

endmodule : dsl_core

`default_nettype wire

// >>> dsl_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// Host side of the serial link; its clock rests low outside frames apart from the stray pulses.
module dsl_host_model (
    // Link pins.
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo
);
    // Chip select rests high, as a pull-up would leave it.
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end

    // One frame of n bits, MSB first; sdo is taken on each rising edge.
    task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] rx);
        rx = 24'h000000;
        #3;
        cs_n = 1'b0;
        for (int i = 23; i > 23 - n; i--) begin
            sdi = w[i];
            #80;
            sclk = 1'b1;
            rx = {rx[22:0], sdo};
            #80;
            sclk = 1'b0;
        end
        #80;
        cs_n = 1'b1;
        sdi = ~sdi; // A deselected line must not keep showing the last bit.
        #160;
    endtask : xfer

    // Stray clock edges while deselected, to prove that they are ignored.
    task automatic stray(input int n);
        repeat (n) begin
            #80;
            sclk = 1'b1;
            sdi = ~sdi;
            #80;
            sclk = 1'b0;
        end
    endtask : stray
endmodule : dsl_host_model

`default_nettype wire

// >>> dsl_pkg.sv
package dsl_pkg;

    // Word geometry: 18 code bits inside a 24-bit serial frame.
    localparam int unsigned CODE_W = 18;
    localparam int unsigned FRAME_W = 24;
    localparam int unsigned BITCNT_W = 5;
    localparam logic [4:0] FRAME_LAST = 5'h17;

    // Reset codes for the input register and the latch, and the top-bit mask for twos complement.
    localparam logic [17:0] RESET_CODE_MID = 18'h20000;
    localparam logic [17:0] RESET_CODE_ZERO = 18'h00000;
    localparam logic [17:0] CODE_MSB = 18'h20000;

    // Full-scale divisor of the transfer function.
    localparam int unsigned FULL_SCALE_DIV = 262144;

    // Synchroniser depth for pins and crossings.
    localparam int unsigned SYNC_STAGES = 2;

    // Static configuration pins gathered together.
    typedef struct packed {
        logic reset_code_select;
        logic gain_select;
        logic code_format_select;
        logic readback_source_select;
    } dsl_cfg_t;

    // Analog-facing state.
    typedef struct packed {
        logic [17:0] code;
        logic gain_two;
        logic powered_down;
    } dsl_out_t;

    // Link-side load sequence states.
    typedef enum logic [1:0] {
        DSL_IDLE = 2'b00,
        DSL_SHIFT = 2'b01,
        DSL_DONE = 2'b11
    } dsl_state_t;

endpackage : dsl_pkg

// >>> dsl_sync.sv
`timescale 1ns/1ns
`default_nettype none

// Two-stage level synchroniser; the first stage feeds only the second.
module dsl_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clocking.
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // Level in and out.
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;

    // Reset to zero; callers choose polarity so zero is the idle level.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            meta <= '0;
            q <= '0;
        end else if (ce) begin
            meta <= d;
            q <= meta;
        end
    end

endmodule : dsl_sync

`default_nettype wire
